// >>> tb/psc_engine_props.sv
// Timing checker for the sequencer outputs of the command engine.
`timescale 1ns/1ps
module psc_engine_props #(
    parameter int unsigned INIT_CYC = 20,
    parameter int unsigned CAL_CYC = 10,
    parameter psc_pkg::psc_cyc6_t CONV_T_CYC = psc_pkg::CONV_T_CYC,
    parameter psc_pkg::psc_cyc6_t CONV_P_CYC = psc_pkg::CONV_P_CYC
) (
    input wire logic MCLK_IN,
    input wire logic SRST_IN,
    input wire logic POWERUP_DONE_FLAG_OUT,
    input wire logic ADC_RUN_OUT,
    input wire logic ADC_PRESS_SEL_OUT,
    input wire logic [2:0] OSR_SEL_OUT,
    input wire logic CAL_RUN_OUT
);
    int up_q;
    int cal_q;
    int t_q;
    int p_q;
    always_ff @(posedge MCLK_IN) begin
        up_q <= (SRST_IN || POWERUP_DONE_FLAG_OUT) ? 0 : up_q + 1;
        cal_q <= CAL_RUN_OUT ? cal_q + 1 : 0;
        t_q <= (ADC_RUN_OUT && !ADC_PRESS_SEL_OUT) ? t_q + 1 : 0;
        p_q <= ADC_PRESS_SEL_OUT ? p_q + 1 : 0;
    end
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (SRST_IN);
    // The start-up count is slack by two, though the flag drop and the release both give exactly INIT_CYC + CAL_CYC.
    property p_pup_len; $rose(POWERUP_DONE_FLAG_OUT) |-> up_q + 2 >= INIT_CYC + CAL_CYC && up_q <= INIT_CYC + CAL_CYC + 2; endproperty
    a_pup_len: assert property (p_pup_len) else $error("power-up length wrong");
    property p_flag_clr; $fell(SRST_IN) |-> !POWERUP_DONE_FLAG_OUT && !ADC_RUN_OUT && !CAL_RUN_OUT; endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("busy or ready after reset");
    property p_cal_rdy; $rose(POWERUP_DONE_FLAG_OUT) |-> $past(CAL_RUN_OUT) || $past(CAL_RUN_OUT, 2); endproperty
    a_cal_rdy: assert property (p_cal_rdy) else $error("ready without calibration");
    property p_cal_len; $fell(CAL_RUN_OUT) |-> cal_q == CAL_CYC; endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
    property p_t_phase; $rose(ADC_PRESS_SEL_OUT) |-> t_q == CONV_T_CYC[OSR_SEL_OUT]; endproperty
    a_t_phase: assert property (p_t_phase) else $error("temperature phase length wrong");
    property p_conv_end; $fell(ADC_RUN_OUT) |-> ##1 (!POWERUP_DONE_FLAG_OUT || $past(p_q) == CONV_P_CYC[OSR_SEL_OUT]
        || ($past(p_q) == 0 && $past(t_q) == CONV_T_CYC[OSR_SEL_OUT])); endproperty
    a_conv_end: assert property (p_conv_end) else $error("conversion length wrong");
    property p_start_rdy; $rose(ADC_RUN_OUT) |-> $past(POWERUP_DONE_FLAG_OUT) && !ADC_PRESS_SEL_OUT && OSR_SEL_OUT <= 3'h5; endproperty
    a_start_rdy: assert property (p_start_rdy) else $error("conversion started wrongly");
    property p_one_job; !(ADC_RUN_OUT && CAL_RUN_OUT); endproperty
    a_one_job: assert property (p_one_job) else $error("conversion and calibration overlap");
endmodule
bind psc_engine psc_engine_props #(.INIT_CYC(INIT_CYC), .CAL_CYC(CAL_CYC), .CONV_T_CYC(CONV_T_CYC),
    .CONV_P_CYC(CONV_P_CYC)) chk_u (.MCLK_IN(MCLK_IN), .SRST_IN(SRST_IN), .POWERUP_DONE_FLAG_OUT(POWERUP_DONE_FLAG_OUT),
    .ADC_RUN_OUT(ADC_RUN_OUT), .ADC_PRESS_SEL_OUT(ADC_PRESS_SEL_OUT), .OSR_SEL_OUT(OSR_SEL_OUT), .CAL_RUN_OUT(CAL_RUN_OUT));

// >>> tb/psc_host_model.sv
// Two-wire bus master model that frames bytes on a link-clock tick.
`timescale 1ns/1ps
module psc_host_model (
    input wire logic lclk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_out
);
    localparam int Q = 105;
    logic [7:0] got_q;
    event got_ev;
    // The clock stands high and the data line is released between frames.
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n * Q) @(posedge lclk_in);
    endtask
    task automatic bit_io(input logic b, output logic s);
        wt(1);
        sda_oe_out = !b;
        wt(1);
        scl_out = 1'b1;
        s = sda_in;
        wt(2);
        scl_out = 1'b0;
    endtask
    task automatic start();
        wt(2);
        sda_oe_out = 1'b1;
        wt(2);
        scl_out = 1'b0;
    endtask
    task automatic stop();
        wt(1);
        sda_oe_out = 1'b1;
        wt(1);
        scl_out = 1'b1;
        wt(2);
        sda_oe_out = 1'b0;
        wt(2);
    endtask
    task automatic put(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        got_q = {7'h00, !s};
        ->got_ev;
    endtask
    // host acknowledges all but the last byte
    task automatic get(input logic last);
        logic [7:0] v;
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
        bit_io(last, s);
        got_q = v;
        ->got_ev;
    endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the pressure sensor command engine.
`timescale 1ns/1ps
module tb_top;
    localparam psc_pkg::psc_cyc6_t CT = '{3000, 50, 40, 30, 20, 10};
    logic mclk = 1'b0;
    logic lclk = 1'b0;
    logic srst = 1'b1;
    logic asel = 1'b0;
    logic [23:0] tr, pr, tc, pc, al, et, ep, ea;
    logic [31:0] lf = 32'h0000_bab8;
    logic [7:0] ha = 8'hEE;
    logic [7:0] bad [4] = '{8'h41, 8'h43, 8'h58, 8'h5C};
    logic [7:0] exp_q [$];
    wire logic scl, oe_h, oe_d, sdo, flag, run, psel, cal, i0, i1;
    logic [5:0] ev = 6'h00;
    wire logic [2:0] oversampling_ratio;
    wire logic sda = !(oe_d | oe_h);
    int fail_count = 0;
    int num_checks = 0;
    always #25 mclk = !mclk;
    initial begin
        #0.7;
        forever #3 lclk = !lclk;
    end
    psc_engine #(.INIT_CYC(400), .CAL_CYC(10), .CONV_T_CYC(CT), .CONV_P_CYC(CT)) dut_u (.MCLK_IN(mclk), .SRST_IN(srst),
        .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sdo), .SDA_OE_OUT(oe_d), .ADDRESS_SELECT_PIN_IN(asel), .TEMP_RAW_IN(tr),
        .PRESS_RAW_IN(pr), .TEMP_COMP_IN(tc), .PRESS_COMP_IN(pc), .ALT_IN(al), .EVENT_IN(ev),
        .POWERUP_DONE_FLAG_OUT(flag), .ADC_RUN_OUT(run), .ADC_PRESS_SEL_OUT(psel), .OSR_SEL_OUT(oversampling_ratio),
        .CAL_RUN_OUT(cal), .INT0_OUT(i0), .INT1_OUT(i1));
    psc_host_model host_u (.lclk_in(lclk), .sda_in(sda), .scl_out(scl), .sda_oe_out(oe_h));
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    always begin
        @(host_u.got_ev);
        chk("bus byte", {16'h0000, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx}, {16'h0000, host_u.got_q});
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic rnd();
        @(negedge mclk);
        lf = lfsr(lf);
        {tr, pr, tc, pc, al} = {lf[23:0], lf[31:8], ~lf[23:0], lf[27:4], lf[11:0], lf[31:20]};
    endtask
    task automatic settle();
        int n;
        n = 0;
        while (!(flag === 1'b1 && run === 1'b0 && cal === 1'b0) && n < 20000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 20000) begin
            fail_count++;
            $display("[ERR] idle wait expected 1 seen 0");
            print_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] b, input logic a);
        exp_q.push_back({7'h00, a});
        host_u.put(b);
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] d, input bit nd, input logic a);
        host_u.start();
        wr(ha, a);
        wr(c, a);
        if (nd) wr(d, a);
        host_u.stop();
    endtask
    task automatic rd(input logic [7:0] c, input logic [47:0] v, input int n);
        cmd(c, 8'h00, 1'b0, 1'b1);
        host_u.start();
        wr(ha | 8'h01, 1'b1);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(v[47 - 8 * i -: 8]);
            host_u.get(i == n - 1);
        end
        host_u.stop();
    endtask
    initial begin
        rnd();
        repeat (6) @(negedge mclk);
        srst = 1'b0;
        settle();
        for (int o = 0; o < 6; o++) begin
            rnd();
            et = tc;
            if (o % 2 == 0) {ep, ea} = {pc, al};
            cmd({3'h2, o[2:0], (o % 2 == 0) ? 2'h0 : 2'h2}, 8'h00, 1'b0, 1'b1);
            settle();
            chk("osr", o, {21'h00_0000, oversampling_ratio});
            rd(8'h10, {et, ep}, 6);
        end
        foreach (bad[i]) begin
            cmd(bad[i], 8'h00, 1'b0, 1'b1);
            @(negedge mclk);
            chk("run", 0, {23'h00_0000, run});
            chk("osr", 5, {21'h00_0000, oversampling_ratio});
        end
        cmd(8'hCF, 8'h00, 1'b1, 1'b1);
        rd(8'h8F, 48'h0000_0000_0000, 1);
        rnd();
        {et, ep, ea} = {tr, pr, al};
        cmd(8'h54, 8'h00, 1'b0, 1'b1);
        settle();
        rd(8'h11, {et, ea}, 6);
        rd(8'h30, {ep, 24'h00_0000}, 3);
        rd(8'h31, {ea, 24'h00_0000}, 3);
        rd(8'h32, {et, 24'h00_0000}, 3);
        cmd(8'h40, 8'h00, 1'b0, 1'b1);
        cmd(8'h28, 8'h00, 1'b0, 1'b1);
        @(negedge mclk);
        chk("cal", 0, {23'h00_0000, cal});
        chk("run", 1, {23'h00_0000, run});
        cmd(8'h06, 8'h00, 1'b0, 1'b1);
        @(negedge mclk);
        chk("flag", 0, {23'h00_0000, flag});
        chk("run", 0, {23'h00_0000, run});
        settle();
        rd(8'h8F, {8'h80, 40'h00_0000_0000}, 1);
        cmd(8'h28, 8'h00, 1'b0, 1'b1);
        settle();
        cmd(8'hCB, 8'h01, 1'b1, 1'b1);
        @(negedge mclk);
        ev = 6'h01;
        @(negedge mclk);
        ev = 6'h00;
        chk("int0", 1, {23'h00_0000, i0});
        chk("int1", 0, {23'h00_0000, i1});
        rnd();
        asel = 1'b1;
        cmd(8'h54, 8'h00, 1'b0, 1'b0);
        chk("run", 0, {23'h00_0000, run});
        ha = 8'hEC;
        cmd(8'h56, 8'h00, 1'b0, 1'b1);
        settle();
        rd(8'h32, {tc, 24'h00_0000}, 3);
        print_verdict();
    end
endmodule

// >>> verilog/psc_engine.sv
`timescale 1ns/1ps
// Top of the pressure sensor command engine: decoder, sequencer, result store and register file.
module psc_engine #(
    parameter int unsigned INIT_CYC = psc_pkg::INIT_CYC,
    parameter int unsigned CAL_CYC = psc_pkg::CAL_CYC,
    parameter psc_pkg::psc_cyc6_t CONV_T_CYC = psc_pkg::CONV_T_CYC,
    parameter psc_pkg::psc_cyc6_t CONV_P_CYC = psc_pkg::CONV_P_CYC
) (
    // System clock and reset
    input wire logic MCLK_IN,
    input wire logic SRST_IN,
    // Two-wire link pins
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    input wire logic ADDRESS_SELECT_PIN_IN,
    // Measurement front end
    input wire logic [23:0] TEMP_RAW_IN,
    input wire logic [23:0] PRESS_RAW_IN,
    input wire logic [23:0] TEMP_COMP_IN,
    input wire logic [23:0] PRESS_COMP_IN,
    input wire logic [23:0] ALT_IN,
    input wire logic [5:0] EVENT_IN,
    // Sequencer status toward the analog side
    output logic POWERUP_DONE_FLAG_OUT,
    output logic ADC_RUN_OUT,
    output logic ADC_PRESS_SEL_OUT,
    output logic [2:0] OSR_SEL_OUT,
    output logic CAL_RUN_OUT,
    // Interrupt pins
    output logic INT0_OUT,
    output logic INT1_OUT
);
    localparam int unsigned CW = psc_pkg::CNT_W;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        logic sel_s1;
        logic sel_s2;
        logic rx_s1;
        logic rx_s2;
        logic rx_seen;
        logic in_frame;
        logic link_rst;
        logic [6:0] dev_addr;
        psc_pkg::psc_state_e st;
        logic [CW-1:0] cnt;
        logic both;
        logic [2:0] oversampling_ratio;
        logic pend_wr;
        logic [5:0] wr_addr;
        logic [15:0][7:0] regs;
        logic [23:0] temp;
        logic [23:0] press;
        logic [23:0] alt;
        logic [47:0] tx_buf;
        logic run;
        logic psel;
        logic cal;
        logic int0;
        logic int1;
    } psc_core_s;

    psc_core_s r_q;
    psc_core_s n;
    logic evt;
    logic start;
    logic stop;
    logic done;
    logic cmps;
    logic clr_src;
    logic [7:0] cmd;
    logic [5:0] irq_w;

    psc_link_if lk ();

    psc_i2c_link u_link (
        .scl_in(SCL_IN),
        .lk(lk.link)
    );

    function automatic logic [CW-1:0] cyc_m1(int unsigned c);
        return CW'(c - 1);
    endfunction

    function automatic logic [7:0] reg_rd(logic [15:0][7:0] regs, logic [5:0] a);
        return (a < psc_pkg::REG_COUNT) ? regs[a[3:0]] : 8'h00;
    endfunction

    // Everything but the synchronisers, the frame tracking and the device address returns to its default.
    function automatic psc_core_s soft_defaults(psc_core_s s);
        psc_core_s d;
        d = s;
        d.st = psc_pkg::ST_INIT;
        d.cnt = cyc_m1(INIT_CYC);
        d.both = 1'b0;
        d.oversampling_ratio = 3'h0;
        d.pend_wr = 1'b0;
        d.wr_addr = 6'h00;
        d.regs = psc_pkg::REG_RESET;
        d.temp = 24'h00_0000;
        d.press = 24'h00_0000;
        d.alt = 24'h00_0000;
        d.tx_buf = 48'h0000_0000_0000;
        d.run = 1'b0;
        d.psel = 1'b0;
        d.cal = 1'b0;
        d.int0 = 1'b0;
        d.int1 = 1'b0;
        return d;
    endfunction

    always_comb begin
        n = r_q;
        cmd = lk.rx_byte;
        clr_src = 1'b0;
        cmps = r_q.regs[psc_pkg::REG_PARAM][psc_pkg::BIT_CMPS_EN];

        n.scl_s1 = SCL_IN;
        n.scl_s2 = r_q.scl_s1;
        n.sda_s1 = SDA_IN;
        n.sda_s2 = r_q.sda_s1;
        n.sda_p = r_q.sda_s2;
        n.sel_s1 = ADDRESS_SELECT_PIN_IN;
        n.sel_s2 = r_q.sel_s1;
        n.dev_addr = {psc_pkg::DEV_ADDR_HI, ~r_q.sel_s2};

        // Start and stop are seen on the system clock because the link clock is quiet there.
        start = r_q.scl_s2 & r_q.sda_p & ~r_q.sda_s2;
        stop = r_q.scl_s2 & ~r_q.sda_p & r_q.sda_s2;
        n.in_frame = start | (r_q.in_frame & ~stop);
        n.link_rst = start | stop | ~r_q.in_frame;

        // The link clears its toggle under reset, so the synchroniser is cleared with it.
        if (r_q.link_rst) begin
            n.rx_s1 = 1'b0;
            n.rx_s2 = 1'b0;
            n.rx_seen = 1'b0;
        end else begin
            n.rx_s1 = lk.rx_tgl;
            n.rx_s2 = r_q.rx_s1;
            n.rx_seen = r_q.rx_s2;
        end
        evt = r_q.rx_s2 ^ r_q.rx_seen;

        done = (r_q.cnt == '0);
        n.cnt = done ? r_q.cnt : r_q.cnt - CW'(1);

        case (r_q.st)
            psc_pkg::ST_INIT: begin
                if (done) begin
                    n.st = psc_pkg::ST_CAL;
                    n.cnt = cyc_m1(CAL_CYC);
                end
            end
            psc_pkg::ST_CAL: begin
                if (done) begin
                    n.st = psc_pkg::ST_SLEEP;
                    n.regs[psc_pkg::REG_EVENT_SRC][psc_pkg::BIT_PUP_DONE] = 1'b1;
                end
            end
            psc_pkg::ST_RECAL: begin
                if (done) begin
                    n.st = psc_pkg::ST_SLEEP;
                end
            end
            psc_pkg::ST_CONV_T: begin
                if (done) begin
                    n.temp = cmps ? TEMP_COMP_IN : TEMP_RAW_IN;
                    if (r_q.both) begin
                        n.st = psc_pkg::ST_CONV_P;
                        n.cnt = cyc_m1(CONV_P_CYC[r_q.oversampling_ratio]);
                    end else begin
                        n.st = psc_pkg::ST_SLEEP;
                    end
                end
            end
            psc_pkg::ST_CONV_P: begin
                if (done) begin
                    n.press = cmps ? PRESS_COMP_IN : PRESS_RAW_IN;
                    n.alt = ALT_IN;
                    n.st = psc_pkg::ST_SLEEP;
                end
            end
            default: begin
                n.st = r_q.st;
            end
        endcase

        if (evt) begin
            if (lk.rx_first) begin
                n.pend_wr = 1'b0;
                if (cmd == psc_pkg::CMD_SOFT_RST) begin
                    n = soft_defaults(n);
                end else if (r_q.st == psc_pkg::ST_SLEEP) begin
                    if (cmd[7:5] == psc_pkg::CONV_PREFIX) begin
                        if (cmd[4:2] <= psc_pkg::OSR_MAX && (cmd[1:0] == psc_pkg::CH_TP || cmd[1:0] == psc_pkg::CH_T)) begin
                            n.st = psc_pkg::ST_CONV_T;
                            n.oversampling_ratio = cmd[4:2];
                            n.both = (cmd[1:0] == psc_pkg::CH_TP);
                            n.cnt = cyc_m1(CONV_T_CYC[cmd[4:2]]);
                        end
                    end else if (cmd == psc_pkg::CMD_RECAL) begin
                        n.st = psc_pkg::ST_RECAL;
                        n.cnt = cyc_m1(CAL_CYC);
                    end else if (cmd == psc_pkg::CMD_READ_TP) begin
                        n.tx_buf = {r_q.temp, r_q.press};
                    end else if (cmd == psc_pkg::CMD_READ_TA) begin
                        n.tx_buf = {r_q.temp, r_q.alt};
                    end else if (cmd == psc_pkg::CMD_READ_P) begin
                        n.tx_buf = {r_q.press, 24'h00_0000};
                    end else if (cmd == psc_pkg::CMD_READ_A) begin
                        n.tx_buf = {r_q.alt, 24'h00_0000};
                    end else if (cmd == psc_pkg::CMD_READ_T) begin
                        n.tx_buf = {r_q.temp, 24'h00_0000};
                    end else if (cmd[7:6] == psc_pkg::REG_RD_PREFIX) begin
                        n.tx_buf = {reg_rd(r_q.regs, cmd[5:0]), 40'h00_0000_0000};
                        clr_src = (cmd[5:0] == {2'h0, psc_pkg::REG_EVENT_SRC});
                    end else if (cmd[7:6] == psc_pkg::REG_WR_PREFIX) begin
                        n.pend_wr = 1'b1;
                        n.wr_addr = cmd[5:0];
                    end
                end
            end else if (r_q.pend_wr) begin
                n.pend_wr = 1'b0;
                if (r_q.wr_addr < psc_pkg::REG_COUNT && r_q.wr_addr[3:0] != psc_pkg::REG_EVENT_SRC) begin
                    n.regs[r_q.wr_addr[3:0]] = cmd;
                end
            end
        end

        // sticky events, a new event beats the read clear
        if (clr_src) begin
            n.regs[psc_pkg::REG_EVENT_SRC][psc_pkg::EVT_W-1:0] = '0;
        end
        n.regs[psc_pkg::REG_EVENT_SRC][psc_pkg::EVT_W-1:0] =
            n.regs[psc_pkg::REG_EVENT_SRC][psc_pkg::EVT_W-1:0] | EVENT_IN;
        irq_w = n.regs[psc_pkg::REG_EVENT_SRC][psc_pkg::EVT_W-1:0] & n.regs[psc_pkg::REG_INT_EN][psc_pkg::EVT_W-1:0];
        n.int0 = |(irq_w & ~n.regs[psc_pkg::REG_INT_CFG][psc_pkg::EVT_W-1:0]);
        n.int1 = |(irq_w & n.regs[psc_pkg::REG_INT_CFG][psc_pkg::EVT_W-1:0]);

        n.run = (n.st == psc_pkg::ST_CONV_T) || (n.st == psc_pkg::ST_CONV_P);
        n.psel = (n.st == psc_pkg::ST_CONV_P);
        n.cal = (n.st == psc_pkg::ST_CAL) || (n.st == psc_pkg::ST_RECAL);

        if (SRST_IN) begin
            n = soft_defaults('0);
            n.link_rst = 1'b1;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        r_q <= n;
    end

    assign lk.link_rst = r_q.link_rst;
    assign lk.sda_in = SDA_IN;
    assign lk.dev_addr = r_q.dev_addr;
    // The buffer only changes on a command in a write frame, so it is still during a read frame.
    assign lk.tx_buf = r_q.tx_buf;

    assign SDA_OUT = lk.sda_o;
    assign SDA_OE_OUT = lk.sda_oe;
    assign POWERUP_DONE_FLAG_OUT = r_q.regs[psc_pkg::REG_EVENT_SRC][psc_pkg::BIT_PUP_DONE];
    assign ADC_RUN_OUT = r_q.run;
    assign ADC_PRESS_SEL_OUT = r_q.psel;
    assign OSR_SEL_OUT = r_q.oversampling_ratio;
    assign CAL_RUN_OUT = r_q.cal;
    assign INT0_OUT = r_q.int0;
    assign INT1_OUT = r_q.int1;
endmodule

// >>> verilog/psc_i2c_link.sv
`timescale 1ns/1ps
// Bit-level two-wire slave running on the link clock.
module psc_i2c_link (
    // Link clock
    input wire logic scl_in,
    // Crossing to the core
    psc_link_if.link lk
);
    typedef enum logic [3:0] {
        M_ADDR = 4'h1,
        M_WR = 4'h2,
        M_RD = 4'h4,
        M_IDLE = 4'h8
    } psc_mode_e;

    typedef struct packed {
        psc_mode_e mode;
        logic [3:0] cnt;
        logic [6:0] sh;
        logic ack;
        logic wr_first;
        logic [2:0] rd_idx;
        logic [7:0] rx_byte;
        logic rx_first;
        logic rx_tgl;
    } psc_link_s;

    localparam psc_link_s RST_S = '{M_ADDR, 4'h0, 7'h00, 1'b0, 1'b1, 3'h0, 8'h00, 1'b0, 1'b0};

    psc_link_s r_q;
    psc_link_s r_d;
    logic [7:0] byte_w;
    logic [7:0] tx_w;
    logic drv0;
    logic oe_q;
    logic o_q;

    function automatic logic [7:0] tx_sel(logic [47:0] tb, logic [2:0] idx);
        return (idx < 3'h6) ? tb[6'(6'h28 - {idx, 3'h0}) +: 8] : 8'hFF;
    endfunction

    always_comb begin
        r_d = r_q;
        byte_w = {r_q.sh, lk.sda_in};
        if (r_q.cnt != 4'h8) begin
            r_d.sh = byte_w[6:0];
            r_d.cnt = r_q.cnt + 4'h1;
            if (r_q.cnt == 4'h7) begin
                r_d.ack = 1'b0;
                case (r_q.mode)
                    M_ADDR: begin
                        r_d.ack = (byte_w[7:1] == lk.dev_addr);
                        r_d.mode = r_d.ack ? (byte_w[0] ? M_RD : M_WR) : M_IDLE;
                    end
                    M_WR: begin
                        r_d.ack = 1'b1;
                        r_d.rx_byte = byte_w;
                        r_d.rx_first = r_q.wr_first;
                        r_d.wr_first = 1'b0;
                        r_d.rx_tgl = ~r_q.rx_tgl;
                    end
                    default: begin
                        r_d.ack = 1'b0;
                    end
                endcase
            end
        end else begin
            r_d.cnt = 4'h0;
            r_d.ack = 1'b0;
            // read frame stops on host nack
            if (r_q.mode == M_RD && !r_q.ack) begin
                if (lk.sda_in) begin
                    r_d.mode = M_IDLE;
                end else begin
                    r_d.rd_idx = r_q.rd_idx + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge scl_in or posedge lk.link_rst) begin
        if (lk.link_rst) begin
            r_q <= RST_S;
        end else begin
            r_q <= r_d;
        end
    end

    // Data changes only on the falling link clock, so it is stable while the clock is high.
    always_comb begin
        tx_w = tx_sel(lk.tx_buf, r_q.rd_idx);
        drv0 = (r_q.cnt == 4'h8) ? r_q.ack : (r_q.mode == M_RD) && !tx_w[~r_q.cnt[2:0]];
    end

    always_ff @(negedge scl_in or posedge lk.link_rst) begin
        if (lk.link_rst) begin
            oe_q <= 1'b0;
            o_q <= 1'b1;
        end else begin
            oe_q <= drv0;
            o_q <= ~drv0;
        end
    end

    assign lk.sda_oe = oe_q;
    assign lk.sda_o = o_q;
    assign lk.rx_byte = r_q.rx_byte;
    assign lk.rx_first = r_q.rx_first;
    assign lk.rx_tgl = r_q.rx_tgl;
endmodule

// >>> verilog/psc_link_if.sv
`timescale 1ns/1ps
// Signals between the core clock domain and the link clock domain.
interface psc_link_if;
    logic link_rst;
    logic sda_in;
    logic [6:0] dev_addr;
    logic [47:0] tx_buf;
    logic [7:0] rx_byte;
    logic rx_first;
    logic rx_tgl;
    logic sda_oe;
    logic sda_o;
    modport link (input link_rst, sda_in, dev_addr, tx_buf, output rx_byte, rx_first, rx_tgl, sda_oe, sda_o);
    modport core (output link_rst, sda_in, dev_addr, tx_buf, input rx_byte, rx_first, rx_tgl, sda_oe, sda_o);
endinterface

// >>> verilog/psc_pkg.sv
// Constants and shared types for the pressure sensor command engine.
// Contract
// - After reset, run power-up initialisation automatically, then sleep; about 400 us.
// - Set the ready flag to one when the power-up sequence completes.
// - Sleep until a valid command, execute it, return to sleep when done.
// - Calibrate the analog circuitry exactly once per power-up, before first sleep.
// - A pressure conversion is always preceded by a temperature conversion.
// - Results stay stored and readable while the device sleeps.
// - Conversion time follows the oversampling ratio; temperature plus pressure takes twice.
// - Results are compensated or raw per the parameter register compensation bit.
// - Command 0x06 aborts everything, restores defaults, reruns full power-up.
// - Conversion byte: prefix 010, 3-bit oversampling field, 2-bit channel field.
// - Channel 00 converts pressure and temperature; 10 converts temperature only.
// - Oversampling codes 000 to 101 select ratios 4096 down to 128.
// - Channel 01 or 11, or oversampling 110 or 111, converts nothing.
// - Command 0x10 returns temperature then pressure, 24 bits each, MSB first.
// - Command 0x11 returns temperature then altitude, 24 bits each, MSB first.
// - Commands 0x30, 0x31, 0x32 return pressure, altitude, temperature, 24 bits.
// - Command 0x28 recalibrates faster than soft reset, then returns to sleep.
// - Top bits 10 read a register, 11 write one; low six bits address.
// - Altitude is updated when the combined conversion completes.
// - Every bus byte travels most significant bit first.
// - Host sends write address then command; device acknowledges a received soft reset.
// - Detected pressure, altitude or temperature events raise the matching interrupt.
// - Address LSB follows the address select pin: write bytes 0xEE or 0xEC.
// - Reads: command in write frame, then read frame returns register or result bytes.
package psc_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int unsigned POWERUP_TIME_US = 400;
    localparam int unsigned CAL_TIME_US = 100;
    localparam int unsigned CAL_CYC = CAL_TIME_US * CYC_PER_US;
    localparam int unsigned INIT_CYC = (POWERUP_TIME_US - CAL_TIME_US) * CYC_PER_US;
    localparam int unsigned CNT_W = 22;

    // Indexed by the oversampling code, 4096 first.
    typedef int unsigned psc_cyc6_t [6];
    localparam psc_cyc6_t CONV_T_NS = '{65_600_000, 32_800_000, 16_400_000, 8_200_000, 4_100_000, 2_100_000};
    localparam psc_cyc6_t CONV_TP_NS = '{131_100_000, 65_600_000, 32_800_000, 16_400_000, 8_200_000, 4_100_000};

    function automatic psc_cyc6_t span_cyc(psc_cyc6_t total_ns, psc_cyc6_t part_ns);
        psc_cyc6_t c;
        for (int i = 0; i < 6; i++) begin
            c[i] = (total_ns[i] - part_ns[i]) / CLK_PERIOD_NS;
        end
        return c;
    endfunction

    localparam psc_cyc6_t CONV_T_CYC = span_cyc(CONV_T_NS, '{default: 0});
    localparam psc_cyc6_t CONV_P_CYC = span_cyc(CONV_TP_NS, CONV_T_NS);

    localparam logic [7:0] CMD_SOFT_RST = 8'h06;
    localparam logic [7:0] CMD_READ_TP = 8'h10;
    localparam logic [7:0] CMD_READ_TA = 8'h11;
    localparam logic [7:0] CMD_READ_P = 8'h30;
    localparam logic [7:0] CMD_READ_A = 8'h31;
    localparam logic [7:0] CMD_READ_T = 8'h32;
    localparam logic [7:0] CMD_RECAL = 8'h28;
    localparam logic [2:0] CONV_PREFIX = 3'h2;
    localparam logic [1:0] REG_RD_PREFIX = 2'h2;
    localparam logic [1:0] REG_WR_PREFIX = 2'h3;
    localparam logic [1:0] CH_TP = 2'h0;
    localparam logic [1:0] CH_T = 2'h2;
    localparam logic [2:0] OSR_MAX = 3'h5;
    localparam logic [5:0] DEV_ADDR_HI = 6'h3B;

    localparam logic [5:0] REG_COUNT = 6'h10;
    localparam logic [3:0] REG_INT_EN = 4'hB;
    localparam logic [3:0] REG_INT_CFG = 4'hC;
    localparam logic [3:0] REG_EVENT_SRC = 4'hD;
    localparam logic [3:0] REG_PARAM = 4'hF;
    localparam int unsigned BIT_PUP_DONE = 6;
    localparam int unsigned BIT_CMPS_EN = 7;
    localparam int unsigned EVT_W = 6;
    localparam logic [15:0][7:0] REG_RESET = {8'h80, 120'h0};

    typedef enum logic [5:0] {
        ST_INIT = 6'h01,
        ST_CAL = 6'h02,
        ST_SLEEP = 6'h04,
        ST_CONV_T = 6'h08,
        ST_CONV_P = 6'h10,
        ST_RECAL = 6'h20
    } psc_state_e;
endpackage
